/* rsf_pkg.sv */
package rsf_pkg;

  localparam logic [7:0] RSF_SFR_ADDR      = 8'hef;
  localparam logic [7:0] RSF_SFR_PAGE      = 8'h00;

  localparam int         RSF_BIT_FLASH     = 6;
  localparam int         RSF_BIT_COMP      = 5;
  localparam int         RSF_BIT_SW        = 4;
  localparam int         RSF_BIT_WDT       = 3;
  localparam int         RSF_BIT_MCD       = 2;
  localparam int         RSF_BIT_POR       = 1;
  localparam int         RSF_BIT_PIN       = 0;

  localparam logic [7:0] RSF_RDATA_RST     = 8'h00;
  localparam logic       RSF_EN_RST        = 1'b0;

  localparam int         RSF_CLK_PERIOD_PS = 25000;
  // missing clock timeout and internal reset pulse width, in ns
  localparam int         RSF_MCD_TIMEOUT_NS = 500;
  localparam int         RSF_HOLD_NS        = 200;
  localparam int         RSF_MCD_CYC_I  = (RSF_MCD_TIMEOUT_NS * 1000 + RSF_CLK_PERIOD_PS - 1)
                                          / RSF_CLK_PERIOD_PS;
  localparam int         RSF_HOLD_CYC_I = (RSF_HOLD_NS * 1000 + RSF_CLK_PERIOD_PS - 1)
                                          / RSF_CLK_PERIOD_PS;
  localparam logic [7:0] RSF_MCD_CYC    = 8'(RSF_MCD_CYC_I);
  localparam logic [7:0] RSF_HOLD_CYC   = 8'(RSF_HOLD_CYC_I);

  // field order matches register bits 6..0
  typedef struct packed {
    logic flash;
    logic comp;
    logic sw;
    logic wdt;
    logic missing_clock_detector;
    logic por;
    logic pin;
  } rsf_flags_t;

  localparam logic [6:0] RSF_FLAGS_POR = 7'h02;
  localparam logic [6:0] RSF_FLAGS_PIN = 7'h01;

  typedef struct packed {
    logic comp_en;
    logic mcd_en;
    logic vdd_en;
  } rsf_enables_t;

  typedef enum logic [1:0] {
    RSF_ST_RUN  = 2'h0,
    RSF_ST_HOLD = 2'h1,
    RSF_ST_PIN  = 2'h3
  } rsf_state_t;

endpackage

/* rsf_reset_source_flags.sv */
`timescale 1ns/1ps
// Operation
// - cause register sits at special register address 0xef, page 0x00.
// - bit 6 reads 1 after a flash access fault reset; read-only.
// - writing bit 5 enables comparator 0 as reset source, active when output low.
// - bit 5 reads 1 when comparator 0 caused the last reset.
// - writing 1 to bit 4 forces a full system reset at once.
// - bit 4 reads 1 after a software forced reset, else 0.
// - bit 3 reads 1 after a watchdog overflow reset; read-only.
// - writing bit 2 enables missing clock detector, which then resets on timeout.
// - bit 2 reads 1 when missing clock timeout caused the last reset.
// - writing bit 1 enables supply monitor as a reset source.
// - bit 1 reads 1 after power-on or supply monitor reset.
// - bit 0 reads 1 when the external reset pin caused the last reset.
// - missing clock detector is a one-shot retriggered by each clock transition.
// - pin flag is set on exit from an external pin reset.
// - internal resets leave the external reset pin untouched.
// - illegal flash read, write, erase or fetch causes a system reset.
module rsf_reset_source_flags
  import rsf_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_page_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       reset_pin_n_in,
  input  wire logic       vdd_ok_in,
  input  wire logic       comp0_out_in,
  input  wire logic       wdt_overflow_in,
  input  wire logic       flash_fault_in,
  input  wire logic       sysclk_mon_in,
  output logic      [7:0] sfr_rdata_out,
  output logic            sys_reset_out
);

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] page);
    reg_hit = (addr == RSF_SFR_ADDR) && (page == RSF_SFR_PAGE);
  endfunction

  rsf_state_t   state_ff;
  rsf_state_t   nxt_state;
  rsf_flags_t   flags_ff;
  rsf_flags_t   nxt_flags;
  rsf_enables_t en_ff;
  rsf_enables_t nxt_en;
  logic [7:0]   hold_cnt_ff;
  logic [7:0]   nxt_hold_cnt;
  logic [7:0]   mcd_cnt_ff;
  logic [7:0]   nxt_mcd_cnt;
  logic         clk_mon_ff;
  logic [7:0]   rdata_ff;
  logic [7:0]   nxt_rdata;
  logic         sys_reset_ff;

  wire          running   = (state_ff == RSF_ST_RUN);
  // the block is in reset while not running, so bus accesses are ignored then
  wire          wr_hit    = running && sfr_wr_in && reg_hit(sfr_addr_in, sfr_page_in);
  wire          rd_hit    = running && sfr_rd_in && reg_hit(sfr_addr_in, sfr_page_in);
  wire          mon_edge  = clk_mon_ff ^ sysclk_mon_in;
  wire          mcd_fire  = en_ff.mcd_en && (mcd_cnt_ff == RSF_MCD_CYC);

  rsf_flags_t   src;
  // pin is sensed only; no internal cause drives it back
  assign src.pin   = ~reset_pin_n_in;
  assign src.por   = en_ff.vdd_en & ~vdd_ok_in;
  assign src.missing_clock_detector   = mcd_fire;
  assign src.wdt   = wdt_overflow_in;
  assign src.sw    = wr_hit & sfr_wdata_in[RSF_BIT_SW];
  assign src.comp  = en_ff.comp_en & ~comp0_out_in;
  assign src.flash = flash_fault_in;

  // lowest set bit wins, so simultaneous causes still leave exactly one flag
  wire [6:0]    src_v     = src;
  wire [6:0]    cause_oh  = src_v & (~src_v + 7'h01);
  wire          any_src   = |src_v;

  always_comb begin
    nxt_state    = state_ff;
    nxt_flags    = flags_ff;
    nxt_hold_cnt = hold_cnt_ff;
    case (state_ff)
      RSF_ST_RUN: begin
        if (src.pin) begin
          nxt_state = RSF_ST_PIN;
        end else if (any_src) begin
          nxt_state    = RSF_ST_HOLD;
          nxt_flags    = rsf_flags_t'(cause_oh);
          nxt_hold_cnt = RSF_HOLD_CYC - 8'h01;
        end
      end
      RSF_ST_PIN: begin
        if (reset_pin_n_in) begin
          nxt_state    = RSF_ST_HOLD;
          nxt_flags    = rsf_flags_t'(RSF_FLAGS_PIN);
          nxt_hold_cnt = RSF_HOLD_CYC - 8'h01;
        end
      end
      RSF_ST_HOLD: begin
        if (src.pin) begin
          nxt_state = RSF_ST_PIN;
        end else if (hold_cnt_ff == 8'h00) begin
          nxt_state = RSF_ST_RUN;
        end else begin
          nxt_hold_cnt = hold_cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = RSF_ST_HOLD;
      end
    endcase
  end

  // enables are only touched by writes and reset_in, so they survive internal resets
  always_comb begin
    nxt_en = en_ff;
    if (wr_hit) begin
      nxt_en.comp_en = sfr_wdata_in[RSF_BIT_COMP];
      nxt_en.mcd_en  = sfr_wdata_in[RSF_BIT_MCD];
      nxt_en.vdd_en  = sfr_wdata_in[RSF_BIT_POR];
    end
  end

  // one-shot: any transition of the watched clock retriggers it
  assign nxt_mcd_cnt = (!en_ff.mcd_en || !running || mon_edge) ? 8'h00 :
                       (mcd_cnt_ff == RSF_MCD_CYC) ? mcd_cnt_ff : mcd_cnt_ff + 8'h01;

  // enable bits read back as cause flags, bit 7 reads zero
  assign nxt_rdata   = rd_hit ? {1'b0, flags_ff} : RSF_RDATA_RST;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff     <= RSF_ST_HOLD;
      flags_ff     <= rsf_flags_t'(RSF_FLAGS_POR);
      en_ff        <= rsf_enables_t'({3{RSF_EN_RST}});
      hold_cnt_ff  <= RSF_HOLD_CYC - 8'h01;
      mcd_cnt_ff   <= 8'h00;
      clk_mon_ff   <= 1'b0;
      rdata_ff     <= RSF_RDATA_RST;
      sys_reset_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      flags_ff     <= nxt_flags;
      en_ff        <= nxt_en;
      hold_cnt_ff  <= nxt_hold_cnt;
      mcd_cnt_ff   <= nxt_mcd_cnt;
      clk_mon_ff   <= sysclk_mon_in;
      rdata_ff     <= nxt_rdata;
      sys_reset_ff <= (nxt_state != RSF_ST_RUN);
    end
  end

  assign sfr_rdata_out = rdata_ff;
  assign sys_reset_out = sys_reset_ff;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_enter_reset(logic flag);
    sys_reset_out && flag;
  endsequence

  chk_addr_decode: assert property (
    sfr_rd_in && !reg_hit(sfr_addr_in, sfr_page_in) |=> sfr_rdata_out == 8'h00)
    else $error("read outside the cause register returned data");

  chk_flash_cause: assert property (
    running && flash_fault_in && src_v == 7'h40 |=> s_enter_reset(flags_ff.flash))
    else $error("flash fault did not reset with flash flag");

  // every other cause is masked out, so a wrongly gated comparator shows up here
  chk_comp_gate: assert property (
    running && !en_ff.comp_en && !comp0_out_in && (src_v & 7'h5f) == 7'h00
      |=> !sys_reset_out)
    else $error("disabled comparator caused a reset");

  chk_sw_force: assert property (
    wr_hit && sfr_wdata_in[RSF_BIT_SW] && !src.pin |=> s_enter_reset(flags_ff.sw) ##1 sys_reset_out)
    else $error("software force did not reset");

  chk_hold_width: assert property (
    $rose(sys_reset_out) && state_ff == RSF_ST_HOLD |-> sys_reset_out[*8])
    else $error("internal reset shorter than hold time");

  chk_hold_end: assert property (
    $rose(sys_reset_out) && state_ff == RSF_ST_HOLD ##0 reset_pin_n_in[*8]
      |=> !sys_reset_out)
    else $error("internal reset longer than hold time");

  chk_mcd_fire: assert property (
    running && mcd_fire && src_v == 7'h04 |=> s_enter_reset(flags_ff.missing_clock_detector))
    else $error("missing clock timeout did not reset");

  chk_mcd_retrig: assert property (
    mon_edge |=> mcd_cnt_ff == 8'h00)
    else $error("clock transition did not retrigger detector");

  chk_pin_exit: assert property (
    state_ff == RSF_ST_PIN && reset_pin_n_in |=> flags_ff == rsf_flags_t'(RSF_FLAGS_PIN))
    else $error("pin flag not set on pin reset exit");

  chk_flag_onehot: assert property (
    !sys_reset_out |-> $onehot(flags_ff))
    else $error("more than one cause flag set");

  chk_en_persist: assert property (
    !wr_hit |=> $stable(en_ff))
    else $error("enable changed without a write");

  chk_vdd_cause: assert property (
    running && src_v == 7'h02 |=> s_enter_reset(flags_ff.por))
    else $error("supply monitor reset without power flag");

  chk_wdt_cause: assert property (
    running && src_v == 7'h08 |=> s_enter_reset(flags_ff.wdt))
    else $error("watchdog overflow did not reset with watchdog flag");

  chk_comp_cause: assert property (
    running && src_v == 7'h20 |=> s_enter_reset(flags_ff.comp))
    else $error("comparator reset without comparator flag");

  chk_pin_entry: assert property (
    !reset_pin_n_in |=> sys_reset_out)
    else $error("low reset pin did not hold the system in reset");

endmodule

/* rsf_cpu_model.sv */
`timescale 1ns/1ps
module rsf_cpu_model
  import rsf_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic [7:0] sfr_rdata_in,
  output logic      [7:0] sfr_addr_out,
  output logic      [7:0] sfr_page_out,
  output logic            sfr_wr_out,
  output logic            sfr_rd_out,
  output logic      [7:0] sfr_wdata_out
);
  initial begin
    sfr_addr_out = 8'h00;
    sfr_page_out = 8'h00;
    sfr_wr_out = 1'b0;
    sfr_rd_out = 1'b0;
    sfr_wdata_out = 8'h00;
  end
  // whole-byte stores only: a read-back merge would re-fire force bits
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(negedge clock_in);
    sfr_addr_out = a;
    sfr_page_out = p;
    sfr_wdata_out = d;
    sfr_wr_out = 1'b1;
    @(negedge clock_in);
    sfr_wr_out = 1'b0;
    sfr_wdata_out = ~d;
  endtask
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
    @(negedge clock_in);
    sfr_addr_out = a;
    sfr_page_out = p;
    sfr_rd_out = 1'b1;
    @(negedge clock_in);
    sfr_rd_out = 1'b0;
    d = sfr_rdata_in;
  endtask
endmodule

/* rsf_reset_source_flags_tb_top.sv */
`timescale 1ns/1ps
module rsf_reset_source_flags_tb_top;
  import rsf_pkg::*;
  typedef struct packed {
    logic [2:0] src;
    logic [7:0] en;
    logic [7:0] exp;
  } rsf_row_t;
  // source 0 wdt, 1 flash, 2 comp, 3 supply, 4 software, 5 clock, 6 pin
  localparam rsf_row_t ROWS [7] = '{{3'h0, 8'h00, 8'h08}, {3'h1, 8'h00, 8'h40},
    {3'h2, 8'h20, 8'h20}, {3'h3, 8'h02, 8'h02}, {3'h4, 8'h10, 8'h10},
    {3'h5, 8'h04, 8'h04}, {3'h6, 8'h00, 8'h01}};
  logic       clock_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       pin_n = 1'b1;
  logic       vdd_ok = 1'b1;
  logic       comp0 = 1'b1;
  logic       wdt = 1'b0;
  logic       flash = 1'b0;
  logic       mon = 1'b0;
  logic       mon_run = 1'b1;
  logic       wr, rd, sys_rst;
  logic [7:0] addr, page, wdata, rdata, rv;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         n;
  rsf_cpu_model cpu (.clock_in(clock_in), .sfr_rdata_in(rdata), .sfr_addr_out(addr),
    .sfr_page_out(page), .sfr_wr_out(wr), .sfr_rd_out(rd), .sfr_wdata_out(wdata));
  rsf_reset_source_flags dut (.clock_in(clock_in), .reset_in(reset_in),
    .sfr_addr_in(addr), .sfr_page_in(page), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_wdata_in(wdata), .reset_pin_n_in(pin_n), .vdd_ok_in(vdd_ok),
    .comp0_out_in(comp0), .wdt_overflow_in(wdt), .flash_fault_in(flash),
    .sysclk_mon_in(mon), .sfr_rdata_out(rdata), .sys_reset_out(sys_rst));
  always #12.5 clock_in = ~clock_in;
  // watched clock keeps toggling so the detector stays retriggered
  always @(negedge clock_in) if (mon_run) mon <= ~mon;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      complete_run;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wait_level(input logic v);
    n = 0;
    while (sys_rst !== v && n < 60) begin
      @(negedge clock_in);
      n++;
    end
    chk("sys_reset_out", {7'h00, v}, {7'h00, sys_rst});
  endtask
  task automatic drive(input logic [2:0] s, input logic v);
    case (s)
      3'h0: wdt = v;
      3'h1: flash = v;
      3'h2: comp0 = !v;
      3'h3: vdd_ok = !v;
      3'h5: mon_run = !v;
      3'h6: pin_n = !v;
      default: ;
    endcase
  endtask
  task automatic reg_wr(input logic [7:0] d);
    cpu.sfr_write(RSF_SFR_ADDR, RSF_SFR_PAGE, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] e);
    cpu.sfr_read(RSF_SFR_ADDR, RSF_SFR_PAGE, rv);
    chk(nm, e, rv);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clock_in);
    reset_in = 1'b0;
    wait_level(1'b0);
    rd_chk("power flags", {1'b0, RSF_FLAGS_POR});
    @(negedge clock_in);
    chk("idle rdata", 8'h00, rdata);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      reg_wr(ROWS[i].en);
      drive(ROWS[i].src, 1'b1);
      wait_level(1'b1);
      drive(ROWS[i].src, 1'b0);
      wait_level(1'b0);
      rd_chk("cause flags", ROWS[i].exp);
      $display("test row %0d done", i);
    end
    reg_wr(8'h10);
    n = 0;
    while (sys_rst === 1'b1 && n < 40) begin
      n++;
      @(negedge clock_in);
    end
    chk("hold cycles", RSF_HOLD_CYC, 8'(n));
    $display("test hold done");
    cpu.sfr_write(8'hee, RSF_SFR_PAGE, 8'h10);
    cpu.sfr_write(RSF_SFR_ADDR, 8'h01, 8'h10);
    repeat (3) @(negedge clock_in);
    chk("foreign write", 8'h00, {7'h00, sys_rst});
    cpu.sfr_read(8'hee, RSF_SFR_PAGE, rv);
    chk("foreign read", 8'h00, rv);
    $display("test decode done");
    wdt = 1'b1;
    pin_n = 1'b0;
    wait_level(1'b1);
    wdt = 1'b0;
    pin_n = 1'b1;
    wait_level(1'b0);
    rd_chk("pin wins", {1'b0, RSF_FLAGS_PIN});
    reg_wr(8'h14);
    wait_level(1'b1);
    wait_level(1'b0);
    mon_run = 1'b0;
    wait_level(1'b1);
    mon_run = 1'b1;
    wait_level(1'b0);
    rd_chk("kept enable", 8'h04);
    $display("test persist done");
    reg_wr(8'h20);
    reset_in = 1'b1;
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    wait_level(1'b0);
    rd_chk("second power", {1'b0, RSF_FLAGS_POR});
    comp0 = 1'b0;
    repeat (3) @(negedge clock_in);
    chk("comp disabled", 8'h00, {7'h00, sys_rst});
    comp0 = 1'b1;
    $display("test second reset done");
    complete_run;
  end
endmodule
